// File: rtcc_calendar.sv
// Calendar counters, hour match, time base control and AHB-Lite register slave
// Contract
// - Compare hour match against current hour count
// - Top two bits both one always match
// - Weekday 1..7, format independent of mode
// - Fields read and written in selected format
// - Day 1..31, month 1..12, reset zero
// - Year 0..99 within current century
// - Busy status 16 slow ticks before update
// - Select 11x halts; 010 restarts after 500ms
// - Count only on select 010 and enable
// - Periodic events at rate of tick code
// - Format bit one binary, zero decimal, reset zero
// - Periodic flag set always, cleared by read
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`include "rtcc_defs.svh"

module rtcc_calendar (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clkEn,
    input  wire logic        clk32k,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             irq
);
    import rtcc_pkg::*;
    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [7:0] toExt(input logic [6:0] v, input logic bin);
        logic [3:0] tens;
        logic [3:0] ones;
        tens = 4'(v / 7'd10);
        ones = 4'(v % 7'd10);
        return bin ? {1'b0, v} : {tens, ones};
    endfunction
    function automatic logic [6:0] toInt(input logic [7:0] v, input logic bin);
        logic [6:0] tens;
        tens = 7'({3'h0, v[7:4]} * 7'd10);
        return bin ? v[6:0] : 7'(tens + {3'h0, v[3:0]});
    endfunction
    function automatic logic [6:0] hourToInt(input logic [7:0] v, input logic bin,
                                             input logic h24);
        logic [6:0] h;
        h = toInt({1'b0, v[6:0]}, bin);
        if (h24) begin
            return toInt(v, bin);
        end else if (h == 7'd12) begin
            return v[7] ? 7'd12 : 7'd0;
        end else begin
            return v[7] ? 7'(h + 7'd12) : h;
        end
    endfunction
    function automatic logic [4:0] monthDays(input logic [6:0] m, input logic [6:0] y);
        case (m)
            7'd4, 7'd6, 7'd9, 7'd11: return 5'd30;
            7'd2:                    return (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
            default:                 return 5'd31;
        endcase
    endfunction
    function automatic logic [14:0] tapMask(input logic [3:0] code);
        logic [3:0] eff;
        eff = (code == 4'h1) ? 4'h8 : (code == 4'h2) ? 4'h9 : code;
        return 15'((16'h0001 << (eff - 4'h1)) - 16'h0001);
    endfunction

    // ****************************************
    // State
    // ****************************************
    rtcc_time_t      now_r;
    logic [7:0]      hourMatch_r;
    logic [2:0]      runSelect_r;
    logic [3:0]      tickCode_r;
    logic            updBusy_r;
    logic            blockEnable_r;
    logic            hour24_r;
    logic            numberFormatBit_r;
    logic            periodicFlag_r;
    rtcc_events_t    irqStatus_r;
    rtcc_events_t    irqMask_r;
    logic [14:0]     div_r;
    logic            clkSync1_r;
    logic            clkSync2_r;
    logic            clkSync3_r;
    rtcc_bus_state_t busState_r;
    logic            wrPend_r;
    logic [5:0]      wrIdx_r;
    logic [5:0]      rdIdx_r;
    logic            tick;
    logic            running;
    logic            halted;
    logic            secTick;
    logic            periodicEv;
    logic            alarmEv;
    logic            addrPhase;
    logic            wrNow;
    logic [7:0]      wrByte;
    logic            rdCapture;
    rtcc_events_t    eventsNow;
    // ****************************************
    // Slow clock synchroniser and edge
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clkSync1_r <= 1'b0;
            clkSync2_r <= 1'b0;
            clkSync3_r <= 1'b0;
        end else if (clkEn) begin
            clkSync1_r <= clk32k;
            clkSync2_r <= clkSync1_r;
            clkSync3_r <= clkSync2_r;
        end
    end
    assign tick = clkSync2_r & ~clkSync3_r;
    assign running = (runSelect_r == 3'b010) && blockEnable_r;
    assign halted = (runSelect_r[2:1] == 2'b11);
    assign secTick = tick && running && (div_r == 15'h7fff);

    // ****************************************
    // Divider chain
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_r <= 15'h0000;
        end else if (clkEn) begin
            if (halted) begin
                div_r <= 15'(`RTCC_RESTART_TICKS);
            end else if (tick && running) begin
                div_r <= div_r + 15'h0001;
            end
        end
    end
    assign periodicEv = tick && running && (tickCode_r != 4'h0)
                        && (((div_r + 15'h0001) & tapMask(tickCode_r)) == 15'h0000);

    // ****************************************
    // Update in progress
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            updBusy_r <= 1'b0;
        end else if (clkEn) begin
            if (secTick || !running) begin
                updBusy_r <= 1'b0;
            end else if (tick && (div_r == 15'(32767 - `RTCC_UIP_LEAD_TICKS))) begin
                updBusy_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // Hour alarm compare
    // ****************************************
    // Wildcard match
    assign alarmEv = secTick && ((hourMatch_r[7:6] == 2'b11)
                     || (hourToInt(hourMatch_r, numberFormatBit_r, hour24_r) == now_r.hour));

    // ****************************************
    // Bus decode
    // ****************************************
    assign addrPhase = hsel && hready && htrans[1] && hreadyout;
    assign wrNow = wrPend_r;
    assign wrByte = hwdata[7:0];
    assign rdCapture = (busState_r == BUS_READ_WAIT);

    // ****************************************
    // Calendar counters
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            now_r <= '0;
        end else if (clkEn) begin
            if (secTick) begin
                if (now_r.sec >= 7'd59) begin
                    now_r.sec <= 7'd0;
                    if (now_r.min >= 7'd59) begin
                        now_r.min <= 7'd0;
                        if (now_r.hour >= 7'd23) begin
                            now_r.hour <= 7'd0;
                            now_r.weekday <= (now_r.weekday >= 7'd7) ? 7'd1
                                             : 7'(now_r.weekday + 7'd1);
                            if (now_r.monthDay >= 7'(monthDays(now_r.month, now_r.year))) begin
                                now_r.monthDay <= 7'd1;
                                if (now_r.month >= 7'd12) begin
                                    now_r.month <= 7'd1;
                                    now_r.year <= (now_r.year >= 7'd99) ? 7'd0
                                                  : 7'(now_r.year + 7'd1);
                                end else begin
                                    now_r.month <= 7'(now_r.month + 7'd1);
                                end
                            end else begin
                                now_r.monthDay <= 7'(now_r.monthDay + 7'd1);
                            end
                        end else begin
                            now_r.hour <= 7'(now_r.hour + 7'd1);
                        end
                    end else begin
                        now_r.min <= 7'(now_r.min + 7'd1);
                    end
                end else begin
                    now_r.sec <= 7'(now_r.sec + 7'd1);
                end
            end
            if (wrNow) begin
                case (wrIdx_r)
                    `RTCC_IDX_WEEKDAY:   now_r.weekday <= wrByte[6:0];
                    `RTCC_IDX_MONTH_DAY: now_r.monthDay <= toInt(wrByte, numberFormatBit_r);
                    `RTCC_IDX_MONTH:     now_r.month <= toInt(wrByte, numberFormatBit_r);
                    `RTCC_IDX_YEAR:      now_r.year <= toInt(wrByte, numberFormatBit_r);
                    default:             ;
                endcase
            end
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hourMatch_r       <= `RTCC_RST_BYTE;
            runSelect_r       <= `RTCC_RST_SELECT;
            tickCode_r        <= `RTCC_RST_CODE;
            blockEnable_r     <= 1'b0;
            hour24_r          <= 1'b0;
            numberFormatBit_r <= 1'b0;
            irqMask_r         <= `RTCC_RST_EVENTS;
        end else if (clkEn && wrNow) begin
            case (wrIdx_r)
                `RTCC_IDX_HOUR_MATCH: hourMatch_r <= wrByte;
                `RTCC_IDX_TIME_BASE: begin
                    runSelect_r <= wrByte[6:4];
                    tickCode_r  <= wrByte[3:0];
                end
                `RTCC_IDX_CONFIG: begin
                    blockEnable_r     <= wrByte[`RTCC_CFG_ENABLE_BIT];
                    hour24_r          <= wrByte[`RTCC_CFG_H24_BIT];
                    numberFormatBit_r <= wrByte[`RTCC_CFG_BINARY_BIT];
                end
                `RTCC_IDX_IRQ_MASK: irqMask_r <= wrByte[2:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Event flags and interrupt
    // ****************************************
    always_comb begin
        eventsNow = '0;
        eventsNow[`RTCC_EV_PERIODIC_BIT] = periodicEv;
        eventsNow[`RTCC_EV_ALARM_BIT]    = alarmEv;
        eventsNow[`RTCC_EV_UPDATE_BIT]   = secTick;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            periodicFlag_r <= 1'b0;
        end else if (clkEn) begin
            if (periodicEv) begin
                periodicFlag_r <= 1'b1;
            end else if (rdCapture && (rdIdx_r == `RTCC_IDX_FLAGS)) begin
                periodicFlag_r <= 1'b0;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqStatus_r <= `RTCC_RST_EVENTS;
        end else if (clkEn) begin
            if (wrNow && (wrIdx_r == `RTCC_IDX_IRQ_STATUS)) begin
                irqStatus_r <= (irqStatus_r & ~wrByte[2:0]) | eventsNow;
            end else begin
                irqStatus_r <= irqStatus_r | eventsNow;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else if (clkEn) begin
            irq <= |(irqStatus_r & irqMask_r);
        end
    end

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busState_r <= BUS_IDLE;
            wrPend_r   <= 1'b0;
            wrIdx_r    <= 6'h00;
            rdIdx_r    <= 6'h00;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else if (clkEn) begin
            hresp    <= 1'b0;
            wrPend_r <= addrPhase && hwrite;
            if (addrPhase) begin
                wrIdx_r <= haddr[7:2];
                rdIdx_r <= haddr[7:2];
            end
            case (busState_r)
                BUS_IDLE: begin
                    if (addrPhase && !hwrite) begin
                        busState_r <= BUS_READ_WAIT;
                        hreadyout  <= 1'b0;
                    end
                end
                default: begin
                    busState_r <= BUS_IDLE;
                    hreadyout  <= 1'b1;
                end
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (clkEn && rdCapture) begin
            hrdata <= 32'h0000_0000;
            case (rdIdx_r)
                `RTCC_IDX_HOUR_MATCH: hrdata[7:0] <= hourMatch_r;
                `RTCC_IDX_WEEKDAY:    hrdata[7:0] <= {1'b0, now_r.weekday};
                `RTCC_IDX_MONTH_DAY:  hrdata[7:0] <= toExt(now_r.monthDay, numberFormatBit_r);
                `RTCC_IDX_MONTH:      hrdata[7:0] <= toExt(now_r.month, numberFormatBit_r);
                `RTCC_IDX_YEAR:       hrdata[7:0] <= toExt(now_r.year, numberFormatBit_r);
                `RTCC_IDX_TIME_BASE:  hrdata[7:0] <= {updBusy_r, runSelect_r, tickCode_r};
                `RTCC_IDX_CONFIG:     hrdata[2:0] <= {numberFormatBit_r, hour24_r,
                                                      blockEnable_r};
                `RTCC_IDX_FLAGS:      hrdata[0] <= periodicFlag_r;
                `RTCC_IDX_IRQ_STATUS: hrdata[2:0] <= irqStatus_r;
                `RTCC_IDX_IRQ_MASK:   hrdata[2:0] <= irqMask_r;
                default:              ;
            endcase
        end
    end
endmodule

// File: rtcc_calendar_asserts.sv
// Port-level checker for the calendar block
`include "rtcc_defs.svh"

module rtcc_calendar_asserts (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        clkEn,
    input wire logic        clk32k,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        irq
);
    // ****************************************
    // Helpers
    // ****************************************
    logic       taken;
    logic [5:0] idx;
    assign taken = hsel & hready & htrans[1] & hreadyout & clkEn;
    assign idx   = haddr[7:2];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ****************************************
    // Assertions
    // ****************************************
    a_read_one_wait: assert property (
        taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state not exactly one cycle");
    a_write_zero_wait: assert property (
        taken && hwrite |=> hreadyout)
        else $error("write inserted a wait state");
    a_resp_okay: assert property (
        hresp == 1'b0)
        else $error("error response seen");
    a_rdata_low_lane: assert property (
        hrdata[31:8] == 24'h0)
        else $error("read data above low byte not zero");
    a_rdata_hold: assert property (
        hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data changed outside capture");
    a_reset_quiet: assert property (
        $fell(rst) |-> hreadyout && hrdata == 32'h0 && !irq)
        else $error("outputs not idle after reset");
    a_stall_single: assert property (
        !hreadyout && clkEn |=> hreadyout)
        else $error("wait state longer than one cycle");
    a_mask_off_irq: assert property (
        (taken && hwrite && idx == `RTCC_IDX_IRQ_MASK) ##1 (hwdata[2:0] == 3'h0)
        |=> ##1 !irq)
        else $error("interrupt high with empty mask");
    a_weekday_range: assert property (
        taken && !hwrite && idx == `RTCC_IDX_WEEKDAY |=> ##1 hrdata[7:3] == 5'h0)
        else $error("weekday read out of range");
    a_unmapped_zero: assert property (
        taken && !hwrite && !(idx inside {[6'h05:6'h0a], [6'h10:6'h13]})
        |=> ##1 hrdata == 32'h0)
        else $error("unmapped read not zero");

    c_read: cover property (taken && !hwrite);
    c_write: cover property (taken && hwrite);
    c_irq_rise: cover property ($rose(irq));
endmodule

bind rtcc_calendar rtcc_calendar_asserts rtcc_calendar_asserts_inst (
    .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .clk32k(clk32k), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq)
);

// File: rtcc_defs.svh
// Offsets, field positions, reset values and timing counts of the calendar block
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define RTCC_IDX_HOUR_MATCH   6'h05
`define RTCC_IDX_WEEKDAY      6'h06
`define RTCC_IDX_MONTH_DAY    6'h07
`define RTCC_IDX_MONTH        6'h08
`define RTCC_IDX_YEAR         6'h09
`define RTCC_IDX_TIME_BASE    6'h0a
`define RTCC_IDX_CONFIG       6'h10
`define RTCC_IDX_FLAGS        6'h11
`define RTCC_IDX_IRQ_STATUS   6'h12
`define RTCC_IDX_IRQ_MASK     6'h13

// ****************************************
// Field positions
// ****************************************
`define RTCC_TB_UIP_BIT       7
`define RTCC_CFG_ENABLE_BIT   0
`define RTCC_CFG_H24_BIT      1
`define RTCC_CFG_BINARY_BIT   2
`define RTCC_EV_PERIODIC_BIT  0
`define RTCC_EV_ALARM_BIT     1
`define RTCC_EV_UPDATE_BIT    2

// ****************************************
// Reset values
// ****************************************
`define RTCC_RST_BYTE         8'h00
`define RTCC_RST_SELECT       3'h0
`define RTCC_RST_CODE         4'h0
`define RTCC_RST_CONFIG       3'h0
`define RTCC_RST_EVENTS       3'h0

// ****************************************
// Timing
// ****************************************
`define RTCC_CLK32_HZ         32768
`define RTCC_RESTART_MS       500
`define RTCC_RESTART_TICKS    (`RTCC_CLK32_HZ * `RTCC_RESTART_MS / 1000)
`define RTCC_UIP_LEAD_TICKS   16

`endif

// File: rtcc_pkg.sv
// Types shared by the calendar block
package rtcc_pkg;

    typedef struct packed {
        logic [6:0] sec;
        logic [6:0] min;
        logic [6:0] hour;
        logic [6:0] weekday;
        logic [6:0] monthDay;
        logic [6:0] month;
        logic [6:0] year;
    } rtcc_time_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_READ_WAIT
    } rtcc_bus_state_t;

    typedef logic [2:0] rtcc_events_t;

endpackage

// File: tb_top.sv
// Self-checking bench for the calendar block
`include "rtcc_defs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rtcc_pkg::*;

    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        clkEn   = 1'b1;
    logic        clk32k  = 1'b0;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic [1:0]  htrans  = 2'b00;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] haddr   = 32'h0;
    logic [31:0] hwdata  = 32'h0;
    logic        hready;
    logic        hreadyout, hresp, irq;
    logic [31:0] hrdata, rdv;
    int          n_mismatch = 0, checks_done = 0, seed = 45, tickCount = 0;
    int          t0, t1, w, dd, m, y;
    logic [7:0]  hm;

    assign hready = hreadyout;
    always #10 sys_clk = ~sys_clk;
    always #40 clk32k = ~clk32k;
    always @(posedge clk32k) tickCount <= tickCount + 1;

    rtcc_calendar rtcc_calendar_inst (
        .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .clk32k(clk32k), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq)
    );

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction
    function automatic int per(input int c);
        return (c == 1) ? 128 : (c == 2) ? 256 : (1 << (c - 1));
    endfunction
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic near(input int got, input int exp);
        check((got >= exp - 3 && got <= exp + 3) ? 32'(exp) : 32'(got), 32'(exp));
    endtask
    task automatic give_up();
        n_mismatch++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        summarize();
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (n >= 40) give_up();
    endtask
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h0, idx, 2'b00};
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        wait_ready();
        rdv = hrdata;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask
    task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h0);
        check(rdv, {24'h0, exp});
    endtask
    task automatic wait_ticks(input int n);
        int s;
        int k;
        s = tickCount;
        k = 0;
        while (tickCount - s < n && k < 8 * n) begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 8 * n) give_up();
    endtask
    task automatic wait_irq(input logic lvl, output int t);
        int n;
        n = 0;
        while (irq !== lvl && n < 5000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 5000) give_up();
        t = tickCount;
    endtask
    task automatic poll_busy(input logic lvl, input int lim, output int t);
        int n;
        n = 0;
        do begin
            bus(1'b0, `RTCC_IDX_TIME_BASE, 8'h0);
            n++;
        end while (rdv[7] !== lvl && n < lim);
        if (n >= lim) give_up();
        t = tickCount;
    endtask
    task automatic measure(input int c);
        int ta, tb;
        wr(`RTCC_IDX_TIME_BASE, 8'h20 | 8'(c));
        wait_irq(1'b1, ta);
        wr(`RTCC_IDX_IRQ_STATUS, 8'h01);
        wait_irq(1'b0, ta);
        wait_irq(1'b1, ta);
        wr(`RTCC_IDX_IRQ_STATUS, 8'h01);
        wait_irq(1'b0, tb);
        wait_irq(1'b1, tb);
        wr(`RTCC_IDX_IRQ_STATUS, 8'h01);
        check(32'(tb - ta), 32'(per(c)));
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 5; i <= 10; i++) rd(6'(i), 8'h00);
        for (int i = 16; i <= 19; i++) rd(6'(i), 8'h00);
        wr(6'h2f, 8'h5a);
        rd(6'h2f, 8'h00);
        $display("test reset_values done");
        for (int k = 0; k < 5; k++) begin
            w  = 1 + {$random(seed)} % 7;
            dd = 1 + {$random(seed)} % 31;
            m  = 1 + {$random(seed)} % 12;
            y  = {$random(seed)} % 100;
            hm = 8'($random(seed));
            if (k == 0) begin
                w  = 7;
                dd = 31;
                m  = 12;
                y  = 99;
            end
            wr(`RTCC_IDX_WEEKDAY, 8'(w));
            wr(`RTCC_IDX_MONTH, bcd(m));
            wr(`RTCC_IDX_MONTH_DAY, bcd(dd));
            wr(`RTCC_IDX_YEAR, bcd(y));
            wr(`RTCC_IDX_HOUR_MATCH, hm);
            rd(`RTCC_IDX_HOUR_MATCH, hm);
            rd(`RTCC_IDX_MONTH_DAY, bcd(dd));
            rd(`RTCC_IDX_MONTH, bcd(m));
            wr(`RTCC_IDX_CONFIG, 8'h04);
            rd(`RTCC_IDX_WEEKDAY, 8'(w));
            rd(`RTCC_IDX_MONTH_DAY, 8'(dd));
            rd(`RTCC_IDX_YEAR, 8'(y));
            wr(`RTCC_IDX_YEAR, 8'(99 - y));
            wr(`RTCC_IDX_CONFIG, 8'h00);
            rd(`RTCC_IDX_YEAR, bcd(99 - y));
            rd(`RTCC_IDX_WEEKDAY, 8'(w));
        end
        $display("test formats done");
        wr(`RTCC_IDX_TIME_BASE, 8'h63);
        wr(`RTCC_IDX_IRQ_MASK, 8'h07);
        wr(`RTCC_IDX_HOUR_MATCH, 8'hc0);
        wr(`RTCC_IDX_CONFIG, 8'h01);
        wait_ticks(200);
        rd(`RTCC_IDX_IRQ_STATUS, 8'h00);
        rd(`RTCC_IDX_TIME_BASE, 8'h63);
        $display("test halt done");
        wr(`RTCC_IDX_TIME_BASE, 8'h20);
        t0 = tickCount;
        clkEn <= 1'b0;
        wait_ticks(50);
        clkEn <= 1'b1;
        poll_busy(1'b1, 17000, t1);
        near(t1 - t0, `RTCC_RESTART_TICKS - `RTCC_UIP_LEAD_TICKS + 50);
        poll_busy(1'b0, 100, t1);
        near(t1 - t0, `RTCC_RESTART_TICKS + 50);
        rd(`RTCC_IDX_IRQ_STATUS, 8'h06);
        check(32'(irq), 32'h1);
        wr(`RTCC_IDX_IRQ_MASK, 8'h00);
        repeat (2) @(posedge sys_clk);
        check(32'(irq), 32'h0);
        wr(`RTCC_IDX_IRQ_MASK, 8'h06);
        repeat (2) @(posedge sys_clk);
        check(32'(irq), 32'h1);
        wr(`RTCC_IDX_IRQ_STATUS, 8'h06);
        rd(`RTCC_IDX_IRQ_STATUS, 8'h00);
        check(32'(irq), 32'h0);
        $display("test restart done");
        wr(`RTCC_IDX_IRQ_MASK, 8'h01);
        for (int c = 1; c <= 9; c++) measure(c);
        wr(`RTCC_IDX_TIME_BASE, 8'h20);
        wr(`RTCC_IDX_IRQ_STATUS, 8'h01);
        rd(`RTCC_IDX_FLAGS, 8'h01);
        rd(`RTCC_IDX_FLAGS, 8'h00);
        wait_ticks(600);
        rd(`RTCC_IDX_IRQ_STATUS, 8'h00);
        check(32'(irq), 32'h0);
        wr(`RTCC_IDX_CONFIG, 8'h00);
        wr(`RTCC_IDX_TIME_BASE, 8'h23);
        wait_ticks(100);
        rd(`RTCC_IDX_IRQ_STATUS, 8'h00);
        $display("test periodic done");
        summarize();
    end
endmodule
